// >>> rtl/irq_router_pkg.sv
// Constants and types shared by the submodule interrupt router.
// Assumes one 125 MHz clock and an AXI4-Lite master holding 8-bit byte addresses.
package irq_router_pkg;

  // Carrier geometry
  localparam int SLOTS     = 3;
  localparam int SRCS      = 3;
  localparam int NSRC      = SLOTS * SRCS;
  localparam int ISA_LINES = 16;
  localparam int LINKS     = 2;

  // Routing codes
  localparam logic [7:0] CODE_GROUP = 8'hF0;
  localparam logic [7:0] CODE_NONE  = 8'hFF;
  localparam logic [7:0] LINE_LIMIT = 8'h10;

  // Byte offsets in the base-settings area
  localparam logic [7:0] ROUTE_BASE  = 8'h00;
  localparam logic [7:0] GROUP_ROUTE = 8'h24;
  localparam logic [7:0] LINK_SEL    = 8'h28;
  localparam logic [7:0] IRQ_STATUS  = 8'h2C;
  localparam logic [7:0] IRQ_MASK    = 8'h30;
  localparam logic [7:0] SRC_LEVEL   = 8'h34;
  localparam logic [7:0] CFG_LAST    = 8'h3F;

  // Values after reset
  localparam logic [7:0] ROUTE_RST = 8'hFF;
  localparam logic [1:0] LINK_RST  = 2'h3;
  localparam logic [8:0] MASK_RST  = 9'h000;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef logic [7:0] route_code_t;

  typedef struct packed {
    logic [1:0] sel1;
    logic [1:0] sel0;
  } link_sel_t;

  typedef struct packed {
    logic [ISA_LINES-1:0] level;
    logic [ISA_LINES-1:0] drive;
  } isa_drive_t;

endpackage

// >>> rtl/irq_route_matrix.sv
// Combinational routing matrix from submodule sources to ISA lines.
// Assumes synchronised active-high source levels and stable route codes.
`timescale 1ns/100ps
module irq_route_matrix (
  // Sources
  input  wire logic [8:0]                        srcLevel,
  input  wire irq_router_pkg::route_code_t [8:0] srcRoute,
  input  wire irq_router_pkg::route_code_t       groupRoute,
  // Results
  output irq_router_pkg::isa_drive_t             drive,
  output logic                                   groupIrq
);

  // Codes at or above the line count, the group code included, hit no line
  function automatic logic hitsLine(input logic [7:0] code, input int line);
    return code == 8'(line);
  endfunction

  logic [8:0] inGroup;

  genvar s;
  genvar l;
  generate
    for (s = 0; s < irq_router_pkg::NSRC; s++) begin : g_grp
      assign inGroup[s] = srcRoute[s] == irq_router_pkg::CODE_GROUP;
    end
  endgenerate

  assign groupIrq = |(srcLevel & inGroup);

  generate
    for (l = 0; l < irq_router_pkg::ISA_LINES; l++) begin : g_line
      logic [8:0] sel;
      logic       grpHit;
      for (s = 0; s < irq_router_pkg::NSRC; s++) begin : g_src
        assign sel[s] = hitsLine(srcRoute[s], l);
      end
      assign grpHit          = hitsLine(groupRoute, l);
      assign drive.drive[l]  = (|sel) | grpHit;
      assign drive.level[l]  = (|(sel & srcLevel)) | (grpHit & groupIrq);
    end
  endgenerate

endmodule // irq_route_matrix

// >>> rtl/submodule_irq_router.sv
// Interrupt routing and signal linking for a three-slot expansion carrier.
// Assumes asynchronous pins from the submodules and an AXI4-Lite master on sys_clk.
// What this block does
// - Takes three interrupt sources per slot, each sent to its configured ISA line.
// - Code F0 sends a source to the group interrupt, never a dedicated line.
// - Any active group-routed source in the module asserts the group interrupt.
// - The group interrupt drives the one ISA line configured for it.
// - Two signals per slot can be linked from any other slot by configuration.
// - Offsets 00h to 37h hold the routing configuration; others are refused.
`timescale 1ns/100ps
module submodule_irq_router (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rstn,
  // AXI4-Lite write
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  // AXI4-Lite read
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  // Submodule slots
  input  wire logic [2:0]  slotIrqFirst,
  input  wire logic [2:0]  slotIrqSecond,
  input  wire logic [2:0]  slotIrqThird,
  input  wire logic [5:0]  linkIn,
  output logic [5:0]       linkOut,
  // ISA lines
  output logic [15:0]      isaIrq,
  output logic [15:0]      isaIrqOe,
  // Interrupt to software
  output logic             irq
);

  // Register index in the base-settings area, or 6'h3F when unmapped
  function automatic logic [5:0] regIndex(input logic [7:0] addr);
    logic [5:0] idx;
    idx = addr[7:2];
    if (addr > irq_router_pkg::CFG_LAST) begin
      return 6'h3F;
    end
    return (idx <= irq_router_pkg::SRC_LEVEL[7:2]) ? idx : 6'h3F;
  endfunction

  // Link source picker; a select of 3 gives a quiet low
  function automatic logic linkPick(input logic [5:0] lv, input logic [1:0] sel, input int k);
    logic [5:0] sh;
    sh = lv >> {sel, 1'b0};
    return (sel == 2'h3) ? 1'b0 : sh[k];
  endfunction

  logic [8:0]  rawSrc;
  logic [8:0]  srcSyncA_reg;
  logic [8:0]  srcSync_reg;
  logic [8:0]  srcPrev_reg;
  logic [5:0]  linkSyncA_reg;
  logic [5:0]  linkSync_reg;
  irq_router_pkg::route_code_t [8:0] route_reg;
  irq_router_pkg::route_code_t       groupRoute_reg;
  irq_router_pkg::link_sel_t   [2:0] linkSel_reg;
  logic [8:0]  status_reg;
  logic [8:0]  mask_reg;
  logic        groupIrq_reg;
  logic [7:0]  awAddr_reg;
  logic [31:0] wData_reg;
  logic [3:0]  wStrb_reg;
  logic        awHeld_reg;
  logic        wHeld_reg;
  irq_router_pkg::isa_drive_t drive;
  logic        groupIrq;
  logic [5:0]  linkOut_next;

  genvar g;
  generate
    for (g = 0; g < irq_router_pkg::SLOTS; g++) begin : g_slot
      assign rawSrc[g*3]     = slotIrqFirst[g];
      assign rawSrc[g*3 + 1] = slotIrqSecond[g];
      assign rawSrc[g*3 + 2] = slotIrqThird[g];
      assign linkOut_next[g*2]     = linkPick(linkSync_reg, linkSel_reg[g].sel0, 0);
      assign linkOut_next[g*2 + 1] = linkPick(linkSync_reg, linkSel_reg[g].sel1, 1);
    end
  endgenerate

  irq_route_matrix u_matrix (
    .srcLevel   (srcSync_reg),
    .srcRoute   (route_reg),
    .groupRoute (groupRoute_reg),
    .drive      (drive),
    .groupIrq   (groupIrq)
  );

  // Pins cross two flops before anything reads them
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      srcSyncA_reg  <= 9'h000;
      srcSync_reg   <= 9'h000;
      srcPrev_reg   <= 9'h000;
      linkSyncA_reg <= 6'h00;
      linkSync_reg  <= 6'h00;
    end else begin
      srcSyncA_reg  <= rawSrc;
      srcSync_reg   <= srcSyncA_reg;
      srcPrev_reg   <= srcSync_reg;
      linkSyncA_reg <= linkIn;
      linkSync_reg  <= linkSyncA_reg;
    end
  end

  // Outputs come from flops; an undriven line shows oe low
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      isaIrq       <= 16'h0000;
      isaIrqOe     <= 16'h0000;
      groupIrq_reg <= 1'b0;
      linkOut      <= 6'h00;
    end else begin
      isaIrq       <= drive.level & drive.drive;
      isaIrqOe     <= drive.drive;
      groupIrq_reg <= groupIrq;
      linkOut      <= linkOut_next;
    end
  end

  // Write path: address and data taken in either order
  logic       doWrite;
  logic [5:0] wIdx;
  logic       wMapped;
  logic [8:0] srcRise;
  logic [8:0] w1c;
  logic [8:0] status_next;

  assign awready     = !awHeld_reg && !bvalid;
  assign wready      = !wHeld_reg && !bvalid;
  assign doWrite     = awHeld_reg && wHeld_reg && !bvalid;
  assign wIdx        = regIndex(awAddr_reg);
  assign wMapped     = wIdx != 6'h3F;
  assign srcRise     = srcSync_reg & ~srcPrev_reg;
  assign w1c         = (doWrite && wIdx == irq_router_pkg::IRQ_STATUS[7:2])
                       ? (wData_reg[8:0] & {wStrb_reg[1], {8{wStrb_reg[0]}}}) : 9'h000;
  assign status_next = (status_reg & ~w1c) | srcRise;
  assign irq         = |(status_reg & mask_reg);

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      awHeld_reg <= 1'b0;
      wHeld_reg  <= 1'b0;
      awAddr_reg <= 8'h00;
      wData_reg  <= 32'h0000_0000;
      wStrb_reg  <= 4'h0;
      bvalid     <= 1'b0;
      bresp      <= irq_router_pkg::RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        awHeld_reg <= 1'b1;
        awAddr_reg <= awaddr;
      end
      if (wvalid && wready) begin
        wHeld_reg <= 1'b1;
        wData_reg <= wdata;
        wStrb_reg <= wstrb;
      end
      if (doWrite) begin
        awHeld_reg <= 1'b0;
        wHeld_reg  <= 1'b0;
        bvalid     <= 1'b1;
        bresp      <= wMapped ? irq_router_pkg::RESP_OKAY : irq_router_pkg::RESP_SLVERR;
      end else if (bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // Configuration registers; byte lanes 0 and 1 carry fields
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      route_reg      <= {irq_router_pkg::NSRC{irq_router_pkg::ROUTE_RST}};
      groupRoute_reg <= irq_router_pkg::ROUTE_RST;
      linkSel_reg    <= {(irq_router_pkg::SLOTS*irq_router_pkg::LINKS){irq_router_pkg::LINK_RST}};
      mask_reg       <= irq_router_pkg::MASK_RST;
      status_reg     <= 9'h000;
    end else begin
      status_reg <= status_next; // Set wins over a same-cycle clear
      if (doWrite && wStrb_reg[0]) begin
        if (wIdx < 6'(irq_router_pkg::NSRC)) begin
          route_reg[wIdx[3:0]] <= wData_reg[7:0];
        end
        if (wIdx == irq_router_pkg::GROUP_ROUTE[7:2]) begin
          groupRoute_reg <= wData_reg[7:0];
        end
        if (wIdx == irq_router_pkg::IRQ_MASK[7:2]) begin
          mask_reg[7:0] <= wData_reg[7:0];
        end
      end
      if (doWrite && wStrb_reg[1]) begin
        if (wIdx == irq_router_pkg::LINK_SEL[7:2]) begin
          linkSel_reg[2] <= wData_reg[11:8];
        end
        if (wIdx == irq_router_pkg::IRQ_MASK[7:2]) begin
          mask_reg[8] <= wData_reg[8];
        end
      end
      if (doWrite && wStrb_reg[0] && wIdx == irq_router_pkg::LINK_SEL[7:2]) begin
        linkSel_reg[1:0] <= wData_reg[7:0];
      end
    end
  end

  // Read path: one read at a time, answered the cycle after the address
  logic [5:0]  rIdx;
  logic [31:0] rWord;

  assign arready = !rvalid;
  assign rIdx    = regIndex(araddr);
  assign rWord   = (rIdx < 6'(irq_router_pkg::NSRC)) ? {24'h000000, route_reg[rIdx[3:0]]} :
                   (rIdx == irq_router_pkg::GROUP_ROUTE[7:2]) ? {24'h000000, groupRoute_reg} :
                   (rIdx == irq_router_pkg::LINK_SEL[7:2])    ? {20'h00000, linkSel_reg} :
                   (rIdx == irq_router_pkg::IRQ_STATUS[7:2])  ? {23'h000000, status_reg} :
                   (rIdx == irq_router_pkg::IRQ_MASK[7:2])    ? {23'h000000, mask_reg} :
                   (rIdx == irq_router_pkg::SRC_LEVEL[7:2])   ? {23'h000000, srcSync_reg} :
                   32'h0000_0000;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rvalid <= 1'b0;
      rdata  <= 32'h0000_0000;
      rresp  <= irq_router_pkg::RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rdata  <= rWord;
      rresp  <= (rIdx == 6'h3F) ? irq_router_pkg::RESP_SLVERR : irq_router_pkg::RESP_OKAY;
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end

  // Checks
  logic anyLine;
  assign anyLine = (groupRoute_reg < irq_router_pkg::LINE_LIMIT) ||
                   (|{route_reg[0] < 8'h10, route_reg[1] < 8'h10, route_reg[2] < 8'h10,
                      route_reg[3] < 8'h10, route_reg[4] < 8'h10, route_reg[5] < 8'h10,
                      route_reg[6] < 8'h10, route_reg[7] < 8'h10, route_reg[8] < 8'h10});

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  a_first_route: assert property (
    srcSync_reg[0] && route_reg[0] < 8'h10 |=>
      isaIrq[$past(route_reg[0][3:0])] && isaIrqOe[$past(route_reg[0][3:0])])
    else $error("Routed source not seen on its ISA line");
  a_group_no_line: assert property (
    srcSync_reg == 9'h001 && route_reg[0] == 8'hF0 && groupRoute_reg >= 8'h10 |=>
      isaIrq == 16'h0000)
    else $error("Group-coded source drove a dedicated line");
  a_group_any: assert property (
    srcSync_reg[4] && route_reg[4] == 8'hF0 |=> groupIrq_reg)
    else $error("Active group member did not raise the group interrupt");
  a_group_line: assert property (
    groupIrq && groupRoute_reg < 8'h10 |=>
      isaIrq[$past(groupRoute_reg[3:0])] && isaIrqOe[$past(groupRoute_reg[3:0])])
    else $error("Group interrupt missing on its ISA line");
  a_link_carry: assert property (
    linkSel_reg[1].sel0 == 2'h0 |=> linkOut[2] == $past(linkSync_reg[0]))
    else $error("Linked signal not carried to the target slot");
  a_cfg_refuse: assert property (
    arvalid && arready && araddr > 8'h3F |=> rvalid && rresp == 2'h2 ##0 rdata == 32'h0000_0000)
    else $error("Access outside the settings area not refused");
  a_line_undriven: assert property (
    !anyLine |=> isaIrqOe == 16'h0000 && isaIrq == 16'h0000)
    else $error("ISA line driven with nothing routed to it");
  a_group_idle: assert property (
    srcSync_reg == 9'h000 |=> !groupIrq_reg)
    else $error("Group interrupt high with all sources low");
  a_status_set: assert property (
    srcRise[0] |=> status_reg[0] [*2] or (status_reg[0] ##1 1'b1))
    else $error("Source edge lost from status");
  a_resp_hold: assert property (
    bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("Write response dropped before taken");

  c_group_out: cover property (groupIrq_reg && groupRoute_reg < 8'h10);
  c_link_used: cover property (linkSel_reg[0].sel0 != 2'h3 ##1 linkOut[0]);
  c_write_done: cover property (bvalid && bready && bresp == 2'h0);
  c_irq_raised: cover property (!irq ##1 irq);

endmodule // submodule_irq_router

// >>> tb/slot_partner.sv
// Behavioural model of the three plug-in submodules on the carrier.
// Assumes the bench sets the source and link patterns just after a clock edge.
`timescale 1ns/100ps
module slot_partner (
  // Patterns from the bench
  input  wire logic [8:0] srcPattern,
  input  wire logic [5:0] linkPattern,
  // Slot pins
  output logic [2:0]      slotIrqFirst,
  output logic [2:0]      slotIrqSecond,
  output logic [2:0]      slotIrqThird,
  output logic [5:0]      linkIn
);
  // Source index is slot*3 plus first, second or third
  always_comb begin
    for (int s = 0; s < 3; s++) begin
      slotIrqFirst[s]  = srcPattern[s*3];
      slotIrqSecond[s] = srcPattern[s*3+1];
      slotIrqThird[s]  = srcPattern[s*3+2];
    end
  end
  assign linkIn = linkPattern;
endmodule // slot_partner

// >>> tb/tb.sv
// Self-checking bench for the submodule interrupt router.
// Assumes a single 125 MHz clock and an AXI4-Lite master that waits for each answer.
`timescale 1ns/100ps
module tb;
  logic        sys_clk, rstn, awvalid, wvalid, arvalid, irq;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, seed, r;
  logic [1:0]  bresp, rresp;
  logic [2:0]  slotIrqFirst, slotIrqSecond, slotIrqThird;
  logic [5:0]  linkIn, linkOut, lnkPat;
  logic [15:0] isaIrq, isaIrqOe;
  logic [8:0]  srcPat, mask, status, prevSrc;
  logic [7:0]  route [9];
  logic [7:0]  grpRoute;
  logic [11:0] linkSel;
  int          fails, checked;

  // Ready lines held high: the bench always accepts answers at once
  submodule_irq_router DUT (
    .sys_clk(sys_clk), .rstn(rstn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(1'h1), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(1'h1),
    .slotIrqFirst(slotIrqFirst), .slotIrqSecond(slotIrqSecond), .slotIrqThird(slotIrqThird),
    .linkIn(linkIn), .linkOut(linkOut), .isaIrq(isaIrq), .isaIrqOe(isaIrqOe), .irq(irq));

  slot_partner slots (
    .srcPattern(srcPat), .linkPattern(lnkPat), .slotIrqFirst(slotIrqFirst),
    .slotIrqSecond(slotIrqSecond), .slotIrqThird(slotIrqThird), .linkIn(linkIn));

  function automatic logic [31:0] rnd();
    seed = {seed[30:0], 1'h0} ^ (seed[31] ? 32'h04C11DB7 : 32'h0);
    return seed;
  endfunction

  task automatic chk_bus(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t bus got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_pin(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t pins got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  // Both channels offered together; each released when taken
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    n = 0;
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'h1;
    wvalid  <= 1'h1;
    do begin
      @(posedge sys_clk);
      n++;
      if (awvalid && awready) awvalid <= 1'h0;
      if (wvalid && wready) wvalid <= 1'h0;
    end while (!bvalid && n < 50);
    chk_bus({29'h0, bvalid, bresp}, {29'h0, 1'h1, er});
  endtask

  task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    int n;
    n = 0;
    araddr  <= a;
    arvalid <= 1'h1;
    do begin
      @(posedge sys_clk);
      n++;
      if (arvalid && arready) arvalid <= 1'h0;
    end while (!rvalid && n < 50);
    chk_bus({29'h0, rvalid, rresp}, {29'h0, 1'h1, er});
    chk_bus(rdata, ed);
  endtask

  // Expected line drive, line levels and link outputs from the current settings
  task automatic chk_pins();
    logic [15:0] drv, lvl;
    logic [5:0]  lo;
    logic        grp;
    int          sel;
    drv = 16'h0;
    lvl = 16'h0;
    grp = 1'h0;
    for (int i = 0; i < 9; i++) begin
      drv[route[i][3:0]] |= (route[i] < 8'h10);
      lvl[route[i][3:0]] |= (route[i] < 8'h10) && srcPat[i];
      grp |= (route[i] == irq_router_pkg::CODE_GROUP) && srcPat[i];
    end
    drv[grpRoute[3:0]] |= (grpRoute < 8'h10);
    lvl[grpRoute[3:0]] |= (grpRoute < 8'h10) && grp;
    for (int k = 0; k < 6; k++) begin
      sel = linkSel[2*k +: 2];
      lo[k] = (sel == 3) ? 1'h0 : lnkPat[sel*2 + k%2];
    end
    chk_pin(isaIrqOe, drv);
    chk_pin(isaIrq, lvl);
    chk_pin({10'h0, linkOut}, {10'h0, lo});
  endtask

  task automatic end_sim();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial begin
    sys_clk = 1'h0;
    forever #4 sys_clk = ~sys_clk;
  end

  // Watchdog well beyond the few thousand cycles the tests need
  initial begin
    tick(50000);
    fails++;
    end_sim();
  end

  initial begin
    rstn = 1'h0; awvalid = 1'h0; wvalid = 1'h0; arvalid = 1'h0;
    awaddr = 8'h0; araddr = 8'h0; wdata = 32'h0; srcPat = 9'h0; lnkPat = 6'h0;
    fails = 0; checked = 0; seed = 32'hB00484A1; grpRoute = 8'hFF; linkSel = 12'hFFF;
    mask = 9'h0; status = 9'h0; prevSrc = 9'h0;
    for (int i = 0; i < 9; i++) route[i] = 8'hFF;
    tick(4);
    rstn <= 1'h1;
    tick(1);
    for (int i = 0; i < 10; i++) axi_rd(8'(4 * i), 32'hFF, 2'h0);
    axi_rd(irq_router_pkg::LINK_SEL, 32'hFFF, 2'h0);
    axi_rd(irq_router_pkg::IRQ_STATUS, 32'h0, 2'h0);
    axi_rd(8'h38, 32'h0, irq_router_pkg::RESP_SLVERR);
    axi_rd(8'h40, 32'h0, irq_router_pkg::RESP_SLVERR);
    axi_wr(8'h80, 32'h5, irq_router_pkg::RESP_SLVERR);
    chk_pins();
    for (int it = 0; it < 40; it++) begin
      for (int i = 0; i < 9; i++) begin
        r = rnd();
        // Group code made common so group members meet often
        route[i] = (i == 8) ? irq_router_pkg::CODE_GROUP :
                   (r[5] ? {4'h0, r[3:0]} : (r[6] ? irq_router_pkg::CODE_GROUP : r[15:8]));
        axi_wr(8'(4 * i), {24'h0, route[i]}, 2'h0);
      end
      r = rnd();
      grpRoute = r[31] ? {4'h0, r[3:0]} : {2'h3, r[30:25]};
      linkSel = r[15:4];
      mask = r[24:16];
      axi_wr(irq_router_pkg::GROUP_ROUTE, {24'h0, grpRoute}, 2'h0);
      axi_wr(irq_router_pkg::LINK_SEL, {20'h0, linkSel}, 2'h0);
      axi_wr(irq_router_pkg::IRQ_MASK, {23'h0, mask}, 2'h0);
      r = rnd();
      srcPat <= r[8:0];
      lnkPat <= r[14:9];
      status = status | (r[8:0] & ~prevSrc);
      prevSrc = r[8:0];
      tick(6);
      chk_pins();
      axi_rd(irq_router_pkg::IRQ_STATUS, {23'h0, status}, 2'h0);
      chk_pin({15'h0, irq}, {15'h0, |(status & mask)});
      axi_rd(irq_router_pkg::SRC_LEVEL, {23'h0, prevSrc}, 2'h0);
      axi_rd(8'(4 * (it % 9)), {24'h0, route[it % 9]}, 2'h0);
      r = rnd();
      axi_wr(irq_router_pkg::IRQ_STATUS, {23'h0, r[8:0]}, 2'h0);
      status = status & ~r[8:0];
      chk_pin({15'h0, irq}, {15'h0, |(status & mask)});
    end
    // Lone group member with no group line, then another member onto line 3
    route[0] = irq_router_pkg::CODE_GROUP;
    route[4] = irq_router_pkg::CODE_GROUP;
    grpRoute = 8'hFF;
    axi_wr(8'h00, {24'h0, route[0]}, 2'h0);
    axi_wr(8'h10, {24'h0, route[4]}, 2'h0);
    axi_wr(irq_router_pkg::GROUP_ROUTE, {24'h0, grpRoute}, 2'h0);
    srcPat <= 9'h001;
    status = status | (9'h001 & ~prevSrc);
    prevSrc = 9'h001;
    tick(6);
    chk_pins();
    grpRoute = 8'h03;
    axi_wr(irq_router_pkg::GROUP_ROUTE, {24'h0, grpRoute}, 2'h0);
    srcPat <= 9'h010;
    status = status | (9'h010 & ~prevSrc);
    prevSrc = 9'h010;
    tick(6);
    chk_pins();
    axi_rd(irq_router_pkg::IRQ_STATUS, {23'h0, status}, 2'h0);
    chk_pin({15'h0, irq}, {15'h0, |(status & mask)});
    end_sim();
  end
endmodule // tb
